// >>> logic/fos_defs.svh
/*
 * constants of the flash option and key-security block: offsets, field positions,
 * reset values and timing counts.
 * assumes it is included by bare name from the package and the design modules.
 */
`ifndef FOS_DEFS_SVH
`define FOS_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on an 8-bit bus)
// ----------------------------------------------------------------------------
`define FOS_OFS_DIVIDER      16'h1820
`define FOS_OFS_OPTION       16'h1821
`define FOS_OFS_CONFIG       16'h1823
`define FOS_KEY_BASE         16'hFFB0
`define FOS_KEY_BYTES        4'h8

// ----------------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------------
`define FOS_CFG_KEYSEL_BIT   5
`define FOS_DIV_LOADED_BIT   7
`define FOS_DIV_PRESCALE_BIT 6
`define FOS_SEC_UNSECURED    2'h2
`define FOS_CFG_RESET        8'h00
`define FOS_DIV_RESET        7'h00
`define FOS_PRESCALE_LAST    3'h7

// ----------------------------------------------------------------------------
// timing: program/erase pulse window against the 20 MHz bus clock
// ----------------------------------------------------------------------------
`define FOS_CLK_NS           50
`define FOS_PULSE_MIN_NS     5000
`define FOS_PULSE_MAX_NS     6700
`define FOS_PULSE_MIN_CYC    ((`FOS_PULSE_MIN_NS + `FOS_CLK_NS - 1) / `FOS_CLK_NS)
`define FOS_PULSE_MAX_CYC    (`FOS_PULSE_MAX_NS / `FOS_CLK_NS)

`endif

// >>> logic/fos_pkg.sv
/*
 * types and the security decode shared by the flash option block.
 * assumes fos_defs.svh is on the include path.
 */
package fos_pkg;
`include "fos_defs.svh"

   // -------------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      FOS_ST_LOAD = 2'h0,
      FOS_ST_RUN  = 2'h1
   } fos_state_t;

   typedef struct packed {
      logic       backdoor_enable;
      logic       vector_redirect_disable;
      logic [3:0] unused;
      logic [1:0] security_code;
   } fos_option_t;

   typedef struct packed {
      logic valid;
      logic from_debug;
   } fos_mem_req_t;

   // only one code unlocks; all others keep the part secure
   function automatic logic fos_is_secure(input logic [1:0] code);
      return code != `FOS_SEC_UNSECURED;
   endfunction

endpackage

// >>> logic/fos_clk_div.sv
/*
 * flash timing clock: optional divide-by-eight, then divide by divisor plus one.
 * assumes a single bus clock and a synchronised active-low reset.
 */
`timescale 1ns/1ps
`include "fos_defs.svh"
module fos_clk_div (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       enable_i,
   input  wire logic       prescale_i,
   input  wire logic [5:0] divisor_i,
   output logic            tick_o,
   output logic            window_ok_o
);
   import fos_pkg::*;

   logic [2:0] pre_cnt_r;
   logic [5:0] div_cnt_r;
   logic [9:0] gap_r;
   logic       seen_r;

   wire logic       pre_en  = !prescale_i || (pre_cnt_r == `FOS_PRESCALE_LAST);
   wire logic       div_end = pre_en && (div_cnt_r == divisor_i);
   wire logic [9:0] period  = ({4'h0, divisor_i} + 10'h001) << (prescale_i ? 3 : 0);

   // ---------------------------------------------------------------------------
   // divider chain
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 6'h00;
         tick_o    <= 1'b0;
      end
      else if (!enable_i)
      begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 6'h00;
         tick_o    <= 1'b0;
      end
      else
      begin
         pre_cnt_r <= pre_cnt_r + 3'h1;
         tick_o    <= div_end;
         if (pre_en)
            div_cnt_r <= div_end ? 6'h00 : div_cnt_r + 6'h01;
      end
   end

   // only a flag: software owns the choice of settings
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         window_ok_o <= 1'b0;
      else
         window_ok_o <= enable_i && (period >= 10'(`FOS_PULSE_MIN_CYC))
                        && (period <= 10'(`FOS_PULSE_MAX_CYC));
   end

   // ---------------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gap_r  <= 10'h001;
         seen_r <= 1'b0;
      end
      else
      begin
         gap_r  <= tick_o ? 10'h001 : gap_r + 10'h001;
         seen_r <= seen_r || tick_o;
      end
   end

   a_tick_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tick_o && seen_r && enable_i) |-> (gap_r == period))
      else $error("flash clock period differs from divider setting");

endmodule // fos_clk_div

// >>> logic/fos_key_compare.sv
/*
 * backdoor comparison-key capture and match.
 * assumes writes arrive already filtered for source and key-select mode.
 */
`timescale 1ns/1ps
`include "fos_defs.svh"
module fos_key_compare (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        restart_i,
   input  wire logic        wr_i,
   input  wire logic [2:0]  idx_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        check_i,
   input  wire logic [63:0] stored_i,
   output logic             match_o
);
   import fos_pkg::*;

   logic [7:0] key_r [8];
   logic [3:0] count_r;
   logic       bad_r;

   function automatic logic keys_equal(input logic [63:0] ref_key);
      logic eq;
      eq = 1'b1;
      for (int i = 0; i < 8; i++)
         eq = eq && (key_r[i] == ref_key[8*i +: 8]);
      return eq;
   endfunction

   wire logic in_order = !count_r[3] && (idx_i == count_r[2:0]);
   wire logic full     = (count_r == `FOS_KEY_BYTES);

   // ---------------------------------------------------------------------------
   // capture: bytes must come in ascending address order
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 8; i++)
            key_r[i] <= 8'h00;
         count_r <= 4'h0;
         bad_r   <= 1'b0;
      end
      else if (restart_i || check_i)
      begin
         count_r <= 4'h0;
         bad_r   <= 1'b0;
      end
      else if (wr_i)
      begin
         if (in_order)
         begin
            key_r[idx_i] <= data_i;
            count_r      <= count_r + 4'h1;
         end
         else
            bad_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         match_o <= 1'b0;
      else
         match_o <= check_i && full && !bad_r && keys_equal(stored_i);
   end

   a_match_needs_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      match_o |-> ($past(count_r) == `FOS_KEY_BYTES) && !$past(bad_r))
      else $error("key match without eight ordered bytes");

endmodule // fos_key_compare

// >>> logic/fos_top.sv
/*
 * flash option shadow, key configuration, backdoor unlock and flash clock divider,
 * reached over an 8-bit Avalon-MM slave with waitrequest.
 * assumes the nonvolatile option byte and stored key are stable at reset release,
 * and that avs_debug_i marks accesses from the background debug interface.
 */
`timescale 1ns/1ps
`include "fos_defs.svh"
module fos_top (
   input  wire logic                  clk_sys_i,
   input  wire logic                  arst_n_i,
   input  wire logic [15:0]           avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [7:0]            avs_writedata_i,
   input  wire logic                  avs_debug_i,
   output logic [7:0]                 avs_readdata_o,
   output logic                       avs_waitrequest_o,
   input  wire logic [7:0]            nonvolatile_option_byte_i,
   input  wire logic [63:0]           stored_backdoor_key_i,
   input  wire logic                  blank_check_pass_i,
   input  wire fos_pkg::fos_mem_req_t mem_req_i,
   output logic                       mem_grant_o,
   output logic                       vector_redirect_disable_o,
   output logic                       secure_o,
   output logic                       flash_cmd_start_o,
   output logic                       flash_clock_tick_o,
   output logic                       flash_timing_ok_o
);
   import fos_pkg::*;

   // ---------------------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------------------
   // option byte is taken three cycles after release; requests wait until then
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   fos_state_t  state_r;
   fos_option_t option_r;
   logic        keysel_r;
   logic        div_loaded_r;
   logic [6:0]  div_r;
   logic        wait_r;
   logic        key_match;

   // ---------------------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------------------
   wire logic run      = (state_r == FOS_ST_RUN);
   wire logic req      = run && (avs_read_i || avs_write_i);
   wire logic first    = req && wait_r;
   wire logic take     = req && !wait_r;
   wire logic wr       = take && avs_write_i;
   wire logic sel_div  = (avs_address_i == `FOS_OFS_DIVIDER);
   wire logic sel_opt  = (avs_address_i == `FOS_OFS_OPTION);
   wire logic sel_cfg  = (avs_address_i == `FOS_OFS_CONFIG);
   wire logic sel_key  = (avs_address_i[15:3] == 13'(`FOS_KEY_BASE >> 3));
   wire logic wd_keysel = avs_writedata_i[`FOS_CFG_KEYSEL_BIT];
   wire logic cfg_wr   = wr && sel_cfg;
   wire logic key_wr   = wr && sel_key && keysel_r && !avs_debug_i;
   wire logic cmd_wr   = wr && sel_key && !keysel_r;
   wire logic key_check = cfg_wr && keysel_r && !wd_keysel;
   wire logic key_restart = cfg_wr && !keysel_r && wd_keysel;
   wire logic unlock   = (key_match && option_r.backdoor_enable)
                         || blank_check_pass_i;

   wire logic [7:0] opt_rd = {option_r.backdoor_enable, option_r.vector_redirect_disable,
                              4'h0, option_r.security_code};
   wire logic [7:0] cfg_rd = {2'h0, keysel_r, 5'h00};
   wire logic [7:0] div_rd = {div_loaded_r, div_r};
   wire logic [7:0] rd_mux = sel_opt ? opt_rd :
                             sel_cfg ? cfg_rd :
                             sel_div ? div_rd : 8'h00;

   // ---------------------------------------------------------------------------
   // option load and Avalon handshake
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r        <= FOS_ST_LOAD;
         wait_r         <= 1'b1;
         avs_readdata_o <= 8'h00;
      end
      else
      begin
         case (state_r)
            FOS_ST_LOAD: state_r <= FOS_ST_RUN;
            FOS_ST_RUN:  state_r <= FOS_ST_RUN;
            default:     state_r <= FOS_ST_LOAD;
         endcase
         wait_r <= !first;
         if (first)
            avs_readdata_o <= rd_mux;
      end
   end

   // one wait state per request keeps the read mux off the pins
   assign avs_waitrequest_o = wait_r;

   // option register: no bus write path at all
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
         option_r <= '0;
      else if (state_r == FOS_ST_LOAD)
      begin
         option_r        <= nonvolatile_option_byte_i;
         option_r.unused <= 4'h0;
      end
      else if (unlock)
         option_r.security_code <= `FOS_SEC_UNSECURED;
   end

   // ---------------------------------------------------------------------------
   // configuration and divider registers
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         keysel_r     <= 1'(`FOS_CFG_RESET >> `FOS_CFG_KEYSEL_BIT);
         div_loaded_r <= 1'b0;
         div_r        <= `FOS_DIV_RESET;
      end
      else
      begin
         if (cfg_wr)
            keysel_r <= wd_keysel;
         if (wr && sel_div && !div_loaded_r)
         begin
            div_loaded_r <= 1'b1;
            div_r        <= avs_writedata_i[6:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         secure_o                  <= 1'b1;
         vector_redirect_disable_o <= 1'b0;
         mem_grant_o               <= 1'b0;
         flash_cmd_start_o         <= 1'b0;
      end
      else
      begin
         secure_o                  <= fos_is_secure(option_r.security_code);
         vector_redirect_disable_o <= option_r.vector_redirect_disable;
         mem_grant_o               <= mem_req_i.valid && !(mem_req_i.from_debug
                                      && fos_is_secure(option_r.security_code));
         flash_cmd_start_o         <= cmd_wr;
      end
   end

   // ---------------------------------------------------------------------------
   // key comparison and flash clock
   // ---------------------------------------------------------------------------
   fos_key_compare u_key (
      .clk_i     (clk_sys_i),
      .rst_n_i   (rst_n),
      .restart_i (key_restart),
      .wr_i      (key_wr),
      .idx_i     (avs_address_i[2:0]),
      .data_i    (avs_writedata_i),
      .check_i   (key_check),
      .stored_i  (stored_backdoor_key_i),
      .match_o   (key_match)
   );

   // flash clock ticks stay off until the divider is written once; command starts are not held back
   fos_clk_div u_div (
      .clk_i       (clk_sys_i),
      .rst_n_i     (rst_n),
      .enable_i    (div_loaded_r),
      .prescale_i  (div_r[`FOS_DIV_PRESCALE_BIT]),
      .divisor_i   (div_r[5:0]),
      .tick_o      (flash_clock_tick_o),
      .window_ok_o (flash_timing_ok_o)
   );

   // ---------------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   sequence s_read_opt;
      first && sel_opt && avs_read_i ##1 !avs_waitrequest_o;
   endsequence

   sequence s_read_cfg;
      first && sel_cfg && avs_read_i ##1 !avs_waitrequest_o;
   endsequence

   a_opt_load_copy: assert property ((state_r == FOS_ST_LOAD) |=>
      (option_r.security_code == $past(nonvolatile_option_byte_i[1:0]))
      && (option_r.backdoor_enable == $past(nonvolatile_option_byte_i[7])))
      else $error("option register not loaded from option byte");

   a_opt_pad_zero: assert property (s_read_opt |-> avs_readdata_o[5:2] == 4'h0)
      else $error("option pad bits read nonzero");

   a_opt_write_none: assert property ((wr && sel_opt && !unlock) |=>
      $stable(option_r))
      else $error("bus write changed option register");

   a_fail_keeps_sec: assert property ((run && !unlock) |=>
      $stable(option_r.security_code))
      else $error("security code changed without an unlock");

   a_match_unlocks: assert property ((key_match && option_r.backdoor_enable) |=>
      (option_r.security_code == `FOS_SEC_UNSECURED) ##1 !secure_o)
      else $error("key match did not unsecure");

   a_debug_key_drop: assert property ((wr && sel_key && avs_debug_i) |-> !key_wr)
      else $error("debug write captured as key byte");

   a_redirect_follow: assert property (run ##1 run |->
      vector_redirect_disable_o == $past(option_r.vector_redirect_disable))
      else $error("redirect disable does not follow option bit 6");

   a_secure_decode: assert property (run ##1 run |->
      secure_o == ($past(option_r.security_code) != 2'h2))
      else $error("security decode wrong");

   a_mem_block: assert property ((mem_req_i.valid && mem_req_i.from_debug && secure_o
      && $stable(option_r.security_code)) |=> !mem_grant_o)
      else $error("debug access granted while secure");

   a_blank_unlock: assert property (blank_check_pass_i |=>
      option_r.security_code == `FOS_SEC_UNSECURED)
      else $error("blank check did not unsecure");

   a_cfg_low_zero: assert property (s_read_cfg |-> avs_readdata_o[4:0] == 5'h00)
      else $error("config low bits read nonzero");

   a_cmd_start: assert property (wr && sel_key |=> flash_cmd_start_o == !$past(keysel_r))
      else $error("key range write routed wrongly");

   a_check_on_clear: assert property (key_match |-> $past(key_check))
      else $error("key match without clearing key select");

   a_opt_read_top: assert property (s_read_opt |->
      avs_readdata_o[7:6] == {option_r.backdoor_enable, option_r.vector_redirect_disable})
      else $error("option read does not show option bits");

   a_cfg_keysel_wr: assert property (cfg_wr |=> keysel_r == $past(wd_keysel))
      else $error("key select does not take the written bit");

   a_div_write_once: assert property ((wr && sel_div && div_loaded_r) |=>
      $stable(div_r))
      else $error("divider changed by a second write");

   a_key_no_cmd: assert property ((wr && sel_key && keysel_r) |=> !flash_cmd_start_o)
      else $error("key byte started a flash command");

   a_mem_pass: assert property ((mem_req_i.valid && !mem_req_i.from_debug) |=> mem_grant_o)
      else $error("user access refused");

   a_unlock_sticky: assert property ((run && option_r.security_code == `FOS_SEC_UNSECURED) |=>
      option_r.security_code == `FOS_SEC_UNSECURED)
      else $error("part fell back to secure before reset");

endmodule // fos_top

// >>> test/fos_tb_top.sv
/*
 * self-checking bench for fos_top: option load, config bits, key unlock, divider.
 * assumes the design files under logic/ and fos_defs.svh on the include path.
 */
`timescale 1ns/1ps
module flash_option_security_config_tb_top;
   import fos_pkg::*;
   // ----------------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------------
   localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
   logic         clk_sys_i = 1'b0;
   logic         arst_n_i  = 1'b0;
   logic [15:0]  addr      = 16'h0000;
   logic         rd        = 1'b0;
   logic         wr        = 1'b0;
   logic [7:0]   wdata     = 8'h00;
   logic         dbg       = 1'b0;
   logic [7:0]   nonvolatile_option_byte     = 8'h00;
   logic         blank     = 1'b0;
   fos_mem_req_t mreq      = '0;
   logic [7:0]   rdata;
   logic         waitreq, grant, vrd, secure, cmd_start, tick, tim_ok;
   int           failures = 0;
   int           n_tests  = 0;
   int           cycles   = 0;
   int           n_cmd    = 0;
   int           last_tick = 0;
   int           tick_period = 0;

   always #25 clk_sys_i = ~clk_sys_i;

   fos_top u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_debug_i(dbg),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .nonvolatile_option_byte_i(nonvolatile_option_byte), .stored_backdoor_key_i(KEY),
      .blank_check_pass_i(blank), .mem_req_i(mreq), .mem_grant_o(grant),
      .vector_redirect_disable_o(vrd), .secure_o(secure), .flash_cmd_start_o(cmd_start),
      .flash_clock_tick_o(tick), .flash_timing_ok_o(tim_ok));

   // hang guard: whole run is well under a thousand cycles
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cmd_start === 1'b1) n_cmd++;
      if (tick === 1'b1)
      begin
         tick_period = cycles - last_tick;
         last_tick   = cycles;
      end
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic results();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic db, output logic [7:0] q);
      @(posedge clk_sys_i);
      addr  <= a;
      wdata <= d;
      dbg   <= db;
      rd    <= ~w;
      wr    <= w;
      do @(posedge clk_sys_i); while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr8(input logic [15:0] a, input logic [7:0] d, input logic db = 1'b0);
      logic [7:0] q;
      bus(1'b1, a, d, db, q);
   endtask

   task automatic rd8(input string what, input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 1'b0, q);
      chk(what, exp, q);
   endtask

   task automatic do_reset(input logic [7:0] opt);
      @(posedge clk_sys_i);
      arst_n_i <= 1'b0;
      nonvolatile_option_byte    <= opt;
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
   endtask

   task automatic try_key(input logic [63:0] k, input logic db);
      wr8(16'h1823, 8'h20);
      for (int i = 0; i < 8; i++) wr8(16'hFFB0 + 16'(i), k[8*i +: 8], db);
      wr8(16'h1823, 8'h00);
      repeat (4) @(posedge clk_sys_i);
   endtask

   task automatic mem_try(input logic from_dbg, input logic exp);
      @(posedge clk_sys_i);
      mreq <= '{valid: 1'b1, from_debug: from_dbg};
      repeat (2) @(posedge clk_sys_i);
      chk("mem_grant", {7'h0, exp}, {7'h0, grant});
      mreq <= '0;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_codes();
      for (int c = 0; c < 4; c++)
      begin
         do_reset({6'h3F, 2'(c)});
         rd8("option", 16'h1821, {6'h30, 2'(c)});
         chk("secure", {7'h0, c != 2}, {7'h0, secure});
         chk("redirect_off", 8'h01, {7'h0, vrd});
      end
   endtask

   task automatic t_regs();
      wr8(16'h1821, 8'h00);
      rd8("option_ro", 16'h1821, 8'hC3);
      wr8(16'h1823, 8'hFF);
      rd8("config_set", 16'h1823, 8'h20);
      wr8(16'h1823, 8'h00);
      rd8("config_clr", 16'h1823, 8'h00);
      rd8("unmapped", 16'h1822, 8'h00);
      n_cmd = 0;
      wr8(16'hFFB7, 8'h55);
      repeat (3) @(posedge clk_sys_i);
      chk("cmd_starts", 8'h01, 8'(n_cmd));
   endtask

   task automatic t_divider();
      chk("timing_ok_pre", 8'h00, {7'h0, tim_ok});
      wr8(16'h1820, 8'h4C);
      wr8(16'h1820, 8'h05);
      rd8("divider", 16'h1820, 8'hCC);
      repeat (320) @(posedge clk_sys_i);
      chk("tick_period", 8'd104, 8'(tick_period));
      chk("timing_ok", 8'h01, {7'h0, tim_ok});
   endtask

   task automatic t_unlock();
      do_reset(8'hC1);
      n_cmd = 0;
      try_key(KEY, 1'b1);
      chk("secure_dbg", 8'h01, {7'h0, secure});
      try_key(KEY ^ 64'h1, 1'b0);
      chk("secure_bad", 8'h01, {7'h0, secure});
      mem_try(1'b1, 1'b0);
      mem_try(1'b0, 1'b1);
      try_key(KEY, 1'b0);
      chk("cmd_none", 8'h00, 8'(n_cmd));
      chk("secure_ok", 8'h00, {7'h0, secure});
      rd8("option_open", 16'h1821, 8'hC2);
      mem_try(1'b1, 1'b1);
   endtask

   task automatic t_backdoor_enable_off();
      do_reset(8'h01);
      chk("redirect_on", 8'h00, {7'h0, vrd});
      try_key(KEY, 1'b0);
      chk("secure_nokey", 8'h01, {7'h0, secure});
      @(posedge clk_sys_i);
      blank <= 1'b1;
      @(posedge clk_sys_i);
      blank <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("secure_blank", 8'h00, {7'h0, secure});
      rd8("option_blank", 16'h1821, 8'h02);
      wr8(16'h1820, 8'h05);
      repeat (20) @(posedge clk_sys_i);
      chk("tick_fast", 8'd6, 8'(tick_period));
      chk("timing_bad", 8'h00, {7'h0, tim_ok});
   endtask

   initial
   begin
      t_codes();
      t_regs();
      t_divider();
      t_unlock();
      t_backdoor_enable_off();
      results();
   end
endmodule // flash_option_security_config_tb_top
